// ### core/txmgc_sync3.v
// Three-stage input synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`include "txmgc_regs.vh"
module txmgc_sync3 (
	input  wire mclk,    // System clock
	input  wire sys_rst, // Asynchronous reset, active high
	input  wire clkEn,   // Clock enable
	input  wire asyncIn, // Input from another domain
	output reg  syncOut  // Filtered level
);
	reg s1Reg;
	reg s2Reg;
	reg s3Reg;

	// First stage feeds only the second stage
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s1Reg   <= 1'b0;
			s2Reg   <= 1'b0;
			s3Reg   <= 1'b0;
			syncOut <= 1'b0;
		end else if (clkEn) begin
			s1Reg <= asyncIn;
			s2Reg <= s1Reg;
			s3Reg <= s2Reg;
			if (s2Reg == s3Reg)
				syncOut <= s3Reg;
		end
	end
endmodule

// ### core/txmgc_top.v
// Lock handling, transmit modulation control and front-end gain selection
`timescale 1ns/1ps
`include "txmgc_regs.vh"
module txmgc_top #(
	parameter RAMP_STEP_CYC = `TXMGC_RAMP_STEP_CYC // Cycles per bias ramp step
) (
	input  wire        mclk,          // 50 MHz reference clock
	input  wire        sys_rst,       // Asynchronous reset, active high
	input  wire        clkEn,         // Freezes all state while low
	input  wire [7:0]  regAddr,       // Register address
	input  wire [7:0]  regWdata,      // Write data
	input  wire        regWr,         // Write strobe
	input  wire        regRd,         // Read strobe
	output reg  [7:0]  regRdata,      // Read data, cycle after strobe
	output reg         irqOut,        // Level interrupt
	input  wire        synthLockPin,  // Analog lock detector, asynchronous
	input  wire        txDataPin,     // Host transmit data, asynchronous
	output reg         bitClockOut,   // Bit clock pulse when shaping on in continuous mode
	output reg  [1:0]  mappableIo,    // Lock indication on selected output
	output reg         txEnable,      // Transmitter enable
	output reg         rxEnable,      // Receiver enable
	output reg         modBit,        // Bit into modulator
	output reg  [13:0] devWord,       // Signed-by-data deviation word magnitude
	output reg         devSign,       // Deviation direction
	output reg  [1:0]  gaussBt,       // 0 off, 1 BT1.0, 2 BT0.5, 3 BT0.3
	output reg  [7:0]  ampBias,       // OOK bias ramp level
	output reg         primaryAmpOn,  // Amplifier on shared_rf_pin
	output reg         boostAmpOn,    // First amplifier on boost_output_pin
	output reg         boosterSecOn,  // Second amplifier on boost_output_pin
	output reg  [7:0]  powerDbm,      // Output power in dBm, two's complement
	output reg  [7:0]  currentMa,     // Current clamp in mA
	output reg         impedance200,  // LNA input 200 ohm when high
	output reg         agcMode,       // Gain under automatic control
	output reg  [2:0]  fixedGainStep  // Fixed gain 1..6, 0 when automatic
);
	reg  [7:0]  ctrlReg;
	reg  [15:0] rateReg;
	reg  [13:0] devReg;
	reg  [7:0]  shapingReg;
	reg  [7:0]  ampLevelReg;
	reg  [7:0]  curLimReg;
	reg  [7:0]  frontGainReg;
	reg  [2:0]  irqStatReg;
	reg  [2:0]  irqMaskReg;
	reg  [15:0] rateCntReg;
	reg         lockPrevReg;
	reg  [15:0] rampCntReg;
	reg         bitTickReg;
	wire        lockSync;
	wire        dataSync;
	wire        seqMode   = ctrlReg[`TXMGC_CTRL_SEQ];
	wire        packetMd  = ctrlReg[`TXMGC_CTRL_PACKET];
	wire        ookMode   = ctrlReg[`TXMGC_CTRL_OOK];
	wire [1:0]  shapeSel  = shapingReg[6:5];
	wire        shapingOn = (shapeSel != 2'b00);
	wire        clocked   = packetMd | shapingOn;
	wire [2:0]  ampBits   = ampLevelReg[7:5];
	wire [4:0]  levelFld  = ampLevelReg[4:0];
	wire        lockRise  = lockSync & ~lockPrevReg;
	wire        rateTick  = (rateCntReg == 16'h0001) || (rateCntReg == 16'h0000);
	wire        ampReserved = (ampBits != 3'b100) && (ampBits != 3'b010) && (ampBits != 3'b011);
	wire [2:0]  irqEvents = {ampReserved & txEnable, bitTickReg, lockRise};
	wire        wrStat    = regWr && (regAddr == `TXMGC_ADDR_IRQSTAT);

	txmgc_sync3 uLockSync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.asyncIn (synthLockPin),
		.syncOut (lockSync)
	);

	txmgc_sync3 uDataSync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clkEn   (clkEn),
		.asyncIn (txDataPin),
		.syncOut (dataSync)
	);

	// Register writes
	// Each divisor and deviation byte takes effect on its own write
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrlReg      <= `TXMGC_CTRL_RST;
			rateReg      <= `TXMGC_RATE_RST;
			devReg       <= `TXMGC_DEV_RST;
			shapingReg   <= `TXMGC_SHAPING_RST;
			ampLevelReg  <= `TXMGC_AMPLEVEL_RST;
			curLimReg    <= `TXMGC_CURLIM_RST;
			frontGainReg <= `TXMGC_FRONTGAIN_RST;
			irqMaskReg   <= 3'h0;
		end else if (clkEn && regWr) begin
			case (regAddr)
			`TXMGC_ADDR_CTRL:      ctrlReg <= regWdata;
			`TXMGC_ADDR_RATE_HI:   rateReg[15:8] <= regWdata;
			`TXMGC_ADDR_RATE_LO:   rateReg[7:0] <= regWdata;
			`TXMGC_ADDR_DEV_HI:    devReg[13:8] <= regWdata[5:0];
			`TXMGC_ADDR_DEV_LO:    devReg[7:0] <= regWdata;
			`TXMGC_ADDR_SHAPING:   shapingReg <= regWdata;
			`TXMGC_ADDR_AMPLEVEL:  ampLevelReg <= regWdata;
			`TXMGC_ADDR_CURLIM:    curLimReg <= regWdata;
			`TXMGC_ADDR_FRONTGAIN: frontGainReg <= regWdata;
			`TXMGC_ADDR_IRQMASK:   irqMaskReg <= regWdata[2:0];
			default: ;
			endcase
		end
	end

	// Sticky status; a new event wins over a write-one clear
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			irqStatReg <= 3'h0;
		else if (clkEn)
			irqStatReg <= (irqStatReg & ~(wrStat ? regWdata[2:0] : 3'h0)) | irqEvents;
	end

	// Read port with one-cycle latency; unmapped addresses read zero
	// Status holds receive, transmit, reserved amplifier code and lock from bit 3 down
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			regRdata <= 8'h00;
		else if (clkEn) begin
			if (regRd) begin
				case (regAddr)
				`TXMGC_ADDR_CTRL:      regRdata <= ctrlReg;
				`TXMGC_ADDR_RATE_HI:   regRdata <= rateReg[15:8];
				`TXMGC_ADDR_RATE_LO:   regRdata <= rateReg[7:0];
				`TXMGC_ADDR_DEV_HI:    regRdata <= {2'b00, devReg[13:8]};
				`TXMGC_ADDR_DEV_LO:    regRdata <= devReg[7:0];
				`TXMGC_ADDR_SHAPING:   regRdata <= shapingReg;
				`TXMGC_ADDR_AMPLEVEL:  regRdata <= ampLevelReg;
				`TXMGC_ADDR_CURLIM:    regRdata <= curLimReg;
				`TXMGC_ADDR_FRONTGAIN: regRdata <= frontGainReg;
				`TXMGC_ADDR_STATUS:    regRdata <= {4'h0, rxEnable, txEnable, ampReserved, lockSync};
				`TXMGC_ADDR_IRQSTAT:   regRdata <= {5'h00, irqStatReg};
				`TXMGC_ADDR_IRQMASK:   regRdata <= {5'h00, irqMaskReg};
				`TXMGC_ADDR_AMPINFO:   regRdata <= powerDbm;
				`TXMGC_ADDR_CURINFO:   regRdata <= currentMa;
				default:               regRdata <= 8'h00;
				endcase
			end else
				regRdata <= 8'h00;
		end
	end

	// Lock tracking and sequencer
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lockPrevReg <= 1'b0;
			txEnable    <= 1'b0;
			rxEnable    <= 1'b0;
		end else if (clkEn) begin
			lockPrevReg <= lockSync;
			// Receive yields to transmit when both are requested
			if (seqMode) begin
				// Enables follow the lock so a lost lock drops the path
				txEnable <= ctrlReg[`TXMGC_CTRL_TXREQ] & lockSync;
				rxEnable <= ctrlReg[`TXMGC_CTRL_RXREQ] & ~ctrlReg[`TXMGC_CTRL_TXREQ] & lockSync;
			end else begin
				// Manual start: host is trusted to have waited for lock
				txEnable <= ctrlReg[`TXMGC_CTRL_TXREQ] & ctrlReg[`TXMGC_CTRL_MANEN];
				rxEnable <= ctrlReg[`TXMGC_CTRL_RXREQ] & ~ctrlReg[`TXMGC_CTRL_TXREQ] &
					ctrlReg[`TXMGC_CTRL_MANEN];
			end
		end
	end

	// Lock routing and interrupt line, each one cycle behind its source
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			mappableIo <= 2'b00;
			irqOut     <= 1'b0;
		end else if (clkEn) begin
			case (ctrlReg[7:6])
			2'b01:   mappableIo <= {1'b0, lockSync};
			2'b10:   mappableIo <= {lockSync, 1'b0};
			default: mappableIo <= 2'b00;
			endcase
			irqOut <= |(irqStatReg & irqMaskReg);
		end
	end

	// Bit-rate divider: one tick every rateReg reference cycles
	// Reloading while idle gives the first bit after enable a full period
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rateCntReg  <= `TXMGC_RATE_RST;
			bitTickReg  <= 1'b0;
			bitClockOut <= 1'b0;
		end else if (clkEn) begin
			bitTickReg <= 1'b0;
			if (!txEnable || !clocked)
				rateCntReg <= rateReg;
			else if (rateTick) begin
				rateCntReg <= rateReg;
				bitTickReg <= 1'b1;
			end else
				rateCntReg <= rateCntReg - 16'h0001;
			// Bit clock is offered to the host only in shaped continuous mode
			bitClockOut <= txEnable && shapingOn && !packetMd && rateTick;
		end
	end

	// Modulation source and FSK deviation
	// A tick takes the bit the host set after the previous pulse: one bit of latency
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			modBit  <= 1'b0;
			devWord <= 14'h0000;
			devSign <= 1'b0;
			gaussBt <= 2'b00;
		end else if (clkEn) begin
			if (!clocked)
				modBit <= dataSync;
			else if (bitTickReg)
				modBit <= dataSync;
			// Step is reference/2^19 applied by the synthesiser fraction
			devWord <= ookMode ? 14'h0000 : devReg;
			devSign <= modBit;
			// Shaping code 1..3 maps to BT 1.0, 0.5, 0.3
			gaussBt <= (ookMode || !txEnable) ? 2'b00 : shapeSel;
		end
	end

	// OOK keying with stepped bias ramp
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rampCntReg <= 16'h0000;
			ampBias    <= 8'h00;
		end else if (clkEn) begin
			if (!ookMode)
				ampBias <= txEnable ? 8'hff : 8'h00;
			else if (!shapingOn)
				ampBias <= (txEnable && modBit) ? 8'hff : 8'h00;
			else if (rampCntReg >= RAMP_STEP_CYC[15:0] - 16'h0001) begin
				rampCntReg <= 16'h0000;
				if (txEnable && modBit && ampBias != 8'hff)
					ampBias <= ampBias + 8'h01;
				else if (!(txEnable && modBit) && ampBias != 8'h00)
					ampBias <= ampBias - 8'h01;
			end else
				rampCntReg <= rampCntReg + 16'h0001;
		end
	end

	// Amplifier mode, power and current clamp
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			primaryAmpOn <= 1'b0;
			boostAmpOn   <= 1'b0;
			boosterSecOn <= 1'b0;
			powerDbm     <= 8'h00;
			currentMa    <= 8'h00;
		end else if (clkEn) begin
			// Reserved codes leave every amplifier off
			primaryAmpOn <= 1'b0;
			boostAmpOn   <= 1'b0;
			boosterSecOn <= 1'b0;
			if (txEnable) begin
				case (ampBits)
				3'b100: primaryAmpOn <= 1'b1;
				3'b010: boostAmpOn   <= 1'b1;
				3'b011: begin
					boostAmpOn   <= 1'b1;
					boosterSecOn <= 1'b1;
				end
				default: ;
				endcase
			end
			powerDbm     <= (ampBits == 3'b011 ? `TXMGC_PWR_COMBINED : `TXMGC_PWR_SINGLE) +
				{3'b000, levelFld};
			currentMa    <= `TXMGC_CUR_BASE + {4'h0, curLimReg[3:0]} * `TXMGC_CUR_STEP;
		end
	end

	// Receive front end
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			impedance200  <= 1'b0;
			agcMode       <= 1'b1;
			fixedGainStep <= 3'b000;
		end else if (clkEn) begin
			impedance200 <= frontGainReg[7];
			case (frontGainReg[2:0])
			3'b000: begin
				agcMode       <= 1'b1;
				fixedGainStep <= 3'b000;
			end
			3'b111: begin
				// Reserved code falls back to automatic control
				agcMode       <= 1'b1;
				fixedGainStep <= 3'b000;
			end
			default: begin
				agcMode       <= 1'b0;
				fixedGainStep <= frontGainReg[2:0];
			end
			endcase
		end
	end
endmodule

// ### shared/txmgc_regs.vh
// Register offsets, field positions, reset values and timing counts of the transmit modulation and gain block
// Behaviour
// - Sequencer enables RX/TX automatically once locked
// - Lock indication high, routable to outputs
// - Unshaped continuous: data sampled asynchronously, no clock
// - Shaped continuous: bit clock pulse per bit
// - Bit rate is reference over 16-bit divisor
// - Deviation is step times 14-bit word
// - OOK keys amplifier with smooth bias ramp; ramps only with shaping on, else hard on/off keying
// - Shaping selects Gaussian BT 0.3/0.5/1
// - Amp enable bits select mode, others reserved
// - Power is -18 or -14 dBm plus level
// - Current clamp is 45 mA plus 5 mA*trim
// - One bit selects 50 or 200 ohm input
// - Gain select: AGC, six fixed gains, reserved
// - Synth step is reference over two^19
`ifndef TXMGC_REGS_VH
`define TXMGC_REGS_VH
`define TXMGC_ADDR_CTRL      8'h00
`define TXMGC_ADDR_RATE_HI   8'h01
`define TXMGC_ADDR_RATE_LO   8'h02
`define TXMGC_ADDR_DEV_HI    8'h03
`define TXMGC_ADDR_DEV_LO    8'h04
`define TXMGC_ADDR_SHAPING   8'h05
`define TXMGC_ADDR_AMPLEVEL  8'h06
`define TXMGC_ADDR_CURLIM    8'h07
`define TXMGC_ADDR_FRONTGAIN 8'h08
`define TXMGC_ADDR_STATUS    8'h09
`define TXMGC_ADDR_IRQSTAT   8'h0a
`define TXMGC_ADDR_IRQMASK   8'h0b
`define TXMGC_ADDR_AMPINFO   8'h0c
`define TXMGC_ADDR_CURINFO   8'h0d
// Control register fields
`define TXMGC_CTRL_SEQ       0
`define TXMGC_CTRL_TXREQ     1
`define TXMGC_CTRL_RXREQ     2
`define TXMGC_CTRL_PACKET    3
`define TXMGC_CTRL_OOK       4
`define TXMGC_CTRL_MANEN     5
`define TXMGC_CTRL_LOCKMAP   6
// Interrupt bits
`define TXMGC_IRQ_LOCK       0
`define TXMGC_IRQ_BITREQ     1
`define TXMGC_IRQ_RESERVED   2
// Reset values
`define TXMGC_CTRL_RST       8'h01
`define TXMGC_SHAPING_RST    8'h09
`define TXMGC_RATE_RST       16'h1a0b
`define TXMGC_DEV_RST        14'h0052
`define TXMGC_AMPLEVEL_RST   8'h9f
`define TXMGC_CURLIM_RST     8'h1a
`define TXMGC_FRONTGAIN_RST  8'h08
// Power and current arithmetic, dBm offsets in two's complement
`define TXMGC_PWR_SINGLE     8'hee
`define TXMGC_PWR_COMBINED   8'hf2
`define TXMGC_CUR_BASE       8'h2d
`define TXMGC_CUR_STEP       8'h05
`define TXMGC_STEP_SHIFT     19
// Bias ramp: time per step in ns and derived cycles at 20 ns
`define TXMGC_RAMP_STEP_NS   1000
`define TXMGC_CLK_NS         20
`define TXMGC_RAMP_STEP_CYC  (`TXMGC_RAMP_STEP_NS / `TXMGC_CLK_NS)
`endif

// ### tb/txmgc_bench.sv
// Self-checking bench of the modulation and gain block
`timescale 1ns/1ps
module txmgc_bench;
	reg         mclk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, synthLockPin = 1'b0, freeRun = 1'b0;
	reg  [7:0]  regAddr = 8'h00, regWdata = 8'h00, e8;
	reg         lastBit, clkEn = 1'b1;
	wire [7:0]  regRdata, ampBias, powerDbm, currentMa;
	wire [13:0] devWord;
	wire [2:0]  fixedGainStep;
	wire [1:0]  mappableIo, gaussBt;
	wire        irqOut, txDataPin, bitClockOut, txEnable, rxEnable, modBit, devSign;
	wire        primaryAmpOn, boostAmpOn, boosterSecOn, impedance200, agcMode;
	integer     n_errors = 0, checked = 0, i, k, seed = 73;
	integer     q[$];
	time        t0;
	// Short ramp step keeps the bias ramp visible within a few bit periods
	txmgc_top #(.RAMP_STEP_CYC(2)) txmgc_top_inst (.*);
	txmgc_host_model txmgc_host_model_inst (.*);
	always #10 mclk = ~mclk;
	function integer xs(input integer s);
		integer t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task tick(input integer n);
		begin
			repeat (n) @(posedge mclk);
			#1;
		end
	endtask
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				n_errors = n_errors + 1;
				$display("BAD %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			if (n_errors == 0 && checked > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	task tmo;
		if (k >= 40) begin
			n_errors = n_errors + 1;
			$display("BAD %0t wait ran out", $time);
			finish_test;
		end
	endtask
	task waitTx(input v);
		begin
			k = 0;
			while (txEnable !== v && k < 40) begin
				tick(1);
				k = k + 1;
			end
			tmo;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge mclk);
			regAddr <= a;
			regWdata <= d;
			regWr <= 1'b1;
			@(posedge mclk);
			regWr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e);
		begin
			@(posedge mclk);
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge mclk);
			regRd <= 1'b0;
			#1;
			chk(regRdata, e);
		end
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		tick(2);
		chk(agcMode, 1);
		rd(8'h0d, 8'h5f);
		rd(8'h0c, 8'h0d);
		rd(8'h2a, 8'h00);
		for (i = 0; i < 16; i = i + 1) begin
			wr(8'h07, i[7:0]);
			tick(2);
			chk(currentMa, 45 + 5 * i);
			wr(8'h08, {i[3], 4'h0, i[2:0]});
			tick(2);
			chk(impedance200, i[3]);
			chk({agcMode, fixedGainStep}, (i % 8 == 0 || i % 8 == 7) ? 8 : i % 8);
		end
		wr(8'h0b, 8'h01);
		wr(8'h00, 8'h43);
		tick(8);
		chk(txEnable, 0);
		@(posedge mclk);
		synthLockPin <= 1'b1;
		waitTx(1);
		tick(2);
		chk(mappableIo, 2'b01);
		chk(irqOut, 1);
		rd(8'h0a, 8'h01);
		wr(8'h0a, 8'h01);
		tick(2);
		chk(irqOut, 0);
		for (i = 0; i < 8; i = i + 1) begin
			seed = xs(seed);
			wr(8'h06, {i[2:0], seed[4:0]});
			tick(2);
			e8 = seed[4:0] + (i == 3 ? 8'hf2 : 8'hee);
			chk({primaryAmpOn, boostAmpOn, boosterSecOn}, (i == 2 || i == 3 || i == 4) ? i : 0);
			if (i == 2 || i == 3 || i == 4) chk(powerDbm, e8);
		end
		rd(8'h0a, 8'h04);
		chk(irqOut, 0);
		wr(8'h0b, 8'h05);
		tick(2);
		chk(irqOut, 1);
		wr(8'h06, 8'h7f);
		wr(8'h0a, 8'h04);
		tick(2);
		chk(irqOut, 0);
		chk(powerDbm, 8'h11);
		wr(8'h03, 8'h2f);
		wr(8'h04, 8'h5a);
		tick(2);
		chk(devWord, 14'h2f5a);
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'h05, {1'b0, i[1:0], 5'h00});
			tick(2);
			chk(gaussBt, i);
		end
		wr(8'h01, 8'h00);
		wr(8'h02, 8'h10);
		wr(8'h05, 8'h20);
		wr(8'h00, 8'h41);
		wr(8'h00, 8'h43);
		for (i = 0; i < 6; i = i + 1) begin
			k = 0;
			while (bitClockOut !== 1'b1 && k < 40) begin
				tick(1);
				k = k + 1;
			end
			tmo;
			if (i > 0) chk(($time - t0) / 20, 16);
			t0 = $time;
			q.push_back(txDataPin);
			tick(2);
			k = q.pop_front();
			chk(modBit, k);
			chk(devSign, k);
		end
		rd(8'h0a, 8'h02);
		wr(8'h05, 8'h00);
		wr(8'h00, 8'h51);
		wr(8'h00, 8'h53);
		@(posedge mclk);
		freeRun <= 1'b1;
		k = 0;
		for (i = 0; i < 96; i = i + 1) begin
			tick(1);
			k = (txDataPin === lastBit) ? k + 1 : 0;
			lastBit = txDataPin;
			if (k >= 8) begin
				chk(ampBias, lastBit ? 8'hff : 8'h00);
				chk(modBit, lastBit);
				chk(devWord, 0);
			end
		end
		@(posedge mclk);
		freeRun <= 1'b0;
		wr(8'h05, 8'h20);
		wr(8'h00, 8'h51);
		wr(8'h00, 8'h53);
		for (i = 0; i < 64; i = i + 1) begin
			k = ampBias;
			tick(1);
			chk((ampBias > k ? ampBias - k : k - ampBias) <= 1, 1);
		end
		wr(8'h00, 8'h44);
		tick(2);
		chk(rxEnable, 0);
		rd(8'h09, 8'h01);
		wr(8'h00, 8'h64);
		tick(2);
		chk({rxEnable, txEnable}, 2'b10);
		@(posedge mclk);
		clkEn <= 1'b0;
		wr(8'h00, 8'h66);
		@(posedge mclk);
		clkEn <= 1'b1;
		tick(2);
		chk({rxEnable, txEnable}, 2'b10);
		wr(8'h00, 8'h47);
		tick(2);
		chk({rxEnable, txEnable}, 2'b01);
		@(posedge mclk);
		synthLockPin <= 1'b0;
		waitTx(0);
		chk(mappableIo, 2'b00);
		finish_test;
	end
endmodule

// ### tb/txmgc_checker.sv
// Port assertions of the modulation and gain block
`timescale 1ns/1ps
module txmgc_checker (
	input wire        mclk,          // Clock
	input wire        sys_rst,       // Reset
	input wire [7:0]  ampBias,       // OOK bias
	input wire [13:0] devWord,       // Deviation
	input wire [1:0]  gaussBt,       // Shaping
	input wire [1:0]  mappableIo,    // Lock route
	input wire [7:0]  powerDbm,      // Power
	input wire [7:0]  currentMa,     // Clamp
	input wire [2:0]  fixedGainStep, // Gain step
	input wire        agcMode,       // Auto gain
	input wire        txEnable,      // Transmit
	input wire        rxEnable,      // Receive
	input wire        bitClockOut,   // Bit clock
	input wire        primaryAmpOn,  // Amp 1
	input wire        boostAmpOn,    // Amp 2
	input wire        boosterSecOn,  // Amp 3
	input wire        synthLockPin   // Lock
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire        [2:0] ampMode = {primaryAmpOn, boostAmpOn, boosterSecOn};
	wire signed [7:0] pwr     = powerDbm;
	chk_amp_legal: assert property (ampMode inside {3'b000, 3'b100, 3'b010, 3'b011})
		else $error("illegal amplifier mode");
	chk_amp_tx_only: assert property (ampMode != 3'b000 |-> txEnable || $past(txEnable))
		else $error("amplifier on while idle");
	chk_power_single: assert property (ampMode == 3'b100 || ampMode == 3'b010 |-> pwr >= -18 && pwr <= 13)
		else $error("single power out of range");
	chk_power_comb: assert property (ampMode == 3'b011 |-> pwr >= -14 && pwr <= 17)
		else $error("combined power out of range");
	chk_current_step: assert property (!$past(sys_rst, 3) |-> currentMa >= 45 && currentMa <= 120 && (currentMa - 45) % 5 == 0)
		else $error("current clamp off grid");
	chk_gain_code: assert property (agcMode == (fixedGainStep == 3'd0) && fixedGainStep != 3'd7)
		else $error("gain code mismatch");
	chk_gauss_tx: assert property (gaussBt != 2'd0 |-> txEnable || $past(txEnable))
		else $error("shaping while idle");
	chk_bitclk_tx: assert property (bitClockOut |-> txEnable || $past(txEnable))
		else $error("bit clock while idle");
	chk_ramp_ook: assert property (ampBias != 8'h00 && ampBias != 8'hff |-> devWord == 14'h0)
		else $error("bias ramp outside keying");
	chk_lock_route: assert property ($rose(mappableIo[0]) |-> $past(synthLockPin, 4))
		else $error("lock output without lock");
	chk_rx_tx_excl: assert property (!(rxEnable && txEnable))
		else $error("receive and transmit together");
	cov_bit_clock: cover property (bitClockOut);
	cov_combined: cover property (ampMode == 3'b011);
	cov_fixed_gain: cover property (!agcMode);
endmodule
bind txmgc_top txmgc_checker txmgc_checker_inst (.*);

// ### tb/txmgc_host_model.sv
// Host model feeding transmit bits to the modulation block
`timescale 1ns/1ps
module txmgc_host_model (
	input  wire mclk,        // Clock
	input  wire sys_rst,     // Reset, active high
	input  wire bitClockOut, // Bit request from the device
	input  wire freeRun,     // Send data with no bit clock
	output reg  txDataPin    // Transmit data to the device
);
	reg [7:0] lfsrReg;
	reg [3:0] gapReg;
	always @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lfsrReg   <= 8'h5b;
			gapReg    <= 4'h0;
			txDataPin <= 1'b0;
		end else begin
			gapReg <= gapReg + 4'h1;
			// New bit after a request, or every 16 cycles in free-run, then held until the next
			if (bitClockOut || (freeRun && gapReg == 4'hf)) begin
				lfsrReg   <= {lfsrReg[6:0], lfsrReg[7] ^ lfsrReg[5] ^ lfsrReg[4] ^ lfsrReg[3]};
				txDataPin <= lfsrReg[0];
			end
		end
	end
endmodule
